// ===== pkg/lrp_pkg.sv
// Purpose: constants and types for the receive path control block
// Assumes: 10 MHz ref_clk, 8-bit register port
// Notes: offsets are byte addresses on the plain register port
package lrp_pkg;
    localparam logic [7:0] ADDR_RX_CFG0 = 8'h07;
    localparam logic [7:0] ADDR_RX_CFG1 = 8'h08;
    localparam logic [7:0] ADDR_RX_CFG2 = 8'h09;
    localparam logic [7:0] ADDR_INT_EDGE = 8'h13;
    localparam logic [7:0] ADDR_STATUS0 = 8'h14;
    localparam logic [7:0] ADDR_STATUS1 = 8'h15;
    localparam logic [7:0] ADDR_INT_STATUS0 = 8'h16;
    localparam logic [7:0] ADDR_TERM = 8'h1a;
    localparam logic [7:0] ADDR_GLOBAL_CFG1 = 8'h60;
    // field positions
    localparam int F_PWRDN = 0;
    localparam int F_INV = 1;
    localparam int F_EDGE = 2;
    localparam int F_MODE = 4;
    localparam int F_EQ_EN = 0;
    localparam int F_SLICER_THRESHOLD_SEL = 0;
    localparam int F_WIN = 2;
    localparam int F_GAIN = 4;
    localparam int F_EDGE_SEL = 0;
    localparam int F_IRQ_MASK = 1;
    localparam int F_OOR = 0;
    localparam int F_FLAG = 0;
    localparam int F_RTERM = 3;
    localparam int F_MON = 0;
    localparam int F_E1 = 4;
    // reset values
    localparam logic [7:0] RST_RX_CFG0 = 8'h00;
    localparam logic [7:0] RST_RX_CFG1 = 8'h01;
    localparam logic [7:0] RST_RX_CFG2 = 8'h08;
    localparam logic [7:0] RST_INT_EDGE = 8'h00;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_GLOBAL_CFG1 = 8'h10;
    // receive modes
    localparam logic [1:0] MODE_SUBST = 2'h0;
    localparam logic [1:0] MODE_AMI = 2'h1;
    localparam logic [1:0] MODE_DUAL = 2'h2;
    localparam logic [1:0] MODE_BYPASS = 2'h3;
    // timing
    localparam longint REF_CLK_HZ = 64'd10000000;
    localparam longint E1_RATE_HZ = 64'd2048000;
    localparam longint T1_RATE_HZ = 64'd1544000;
    localparam longint NCO_SPAN = 64'd65536;
    localparam logic [15:0] NCO_INC_E1 =
        16'((E1_RATE_HZ * NCO_SPAN) / REF_CLK_HZ);
    localparam logic [15:0] NCO_INC_T1 =
        16'((T1_RATE_HZ * NCO_SPAN) / REF_CLK_HZ);
    localparam logic [15:0] NCO_ALIGN = 16'h4000;
    localparam logic [7:0] WIN_BASE = 8'h20;
    typedef struct packed {
        logic pos;
        logic neg;
    } lrp_rail_type;
endpackage

// ===== logic/lrp_receive_path.sv
// Purpose: receive path control, recovery, decoding and output of a channel
// Assumes: sliced marks and peak level arrive synchronous to ref_clk
// Notes: recovered clock is an NCO, so its edges sit on ref_clk edges
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lrp_receive_path #(
    parameter int NCH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // line side
    input wire lrp_pkg::lrp_rail_type slicer_in,
    input wire logic [7:0] amp_peak,
    input wire logic los_detect,
    input wire lrp_pkg::lrp_rail_type [NCH-1:1] mon_rx,
    input wire lrp_pkg::lrp_rail_type [NCH-1:1] mon_tx,
    input wire logic remote_loopback,
    // analog controls
    output logic term_enable,
    output logic [1:0] term_sel,
    output logic [1:0] monitor_gain_sel,
    output logic [1:0] slicer_threshold_sel,
    output logic equalizer_enable,
    // system side
    output logic rx_clock_out,
    output logic rx_data_pos,
    output logic rx_data_neg,
    output logic signal_loss_out,
    output logic equalizer_irq_flag,
    // channel 1 transmit pair in loopback
    output lrp_pkg::lrp_rail_type line_tx_pair_ch1,
    output logic line_tx_drive
);
    import lrp_pkg::*;

    logic [7:0] rx_cfg0, rx_cfg1, rx_cfg2, int_edge, term, gcfg1;
    logic [1:0] rx_mode_sel;
    logic rx_data_invert, clk_edge_sel, power_down, e1_mode;
    logic equalizer_edge_sel, irq_mask;
    logic [3:0] monitor_channel_sel;
    logic [2:0] mon_ch;
    logic mon_on, mon_q;
    lrp_rail_type next_src, src_q;
    logic mark_q, mark_d, pulse_in;
    logic [15:0] phase, nco_inc;
    logic ph_d, rise_ev, fall_ev, upd_ev;
    logic pos_seen, neg_seen, sym_pos, sym_neg;
    logic [7:0] sh_p, sh_n, sh_cv;
    logic [7:0] next_p, next_n, next_cv, w_m, clr;
    logic last_pol, have_mark, new_m, viol;
    logic hdb3, b8zs, exempt, subst;
    logic [7:0] win_cnt, peak, pk;
    logic win_end;
    logic [4:0] cable_atten_level;
    logic equalizer_out_of_range, eqs_d, eq_event, clr_read;

    assign rx_mode_sel = rx_cfg0[F_MODE +: 2];
    assign rx_data_invert = rx_cfg0[F_INV];
    assign clk_edge_sel = rx_cfg0[F_EDGE];
    assign power_down = rx_cfg0[F_PWRDN];
    assign e1_mode = gcfg1[F_E1];
    assign equalizer_edge_sel = int_edge[F_EDGE_SEL];
    assign irq_mask = int_edge[F_IRQ_MASK];
    assign monitor_channel_sel = gcfg1[F_MON +: 4];
    assign mon_ch = monitor_channel_sel[2:0];

    function automatic logic [7:0] win_limit(input logic [1:0] sel);
        win_limit = 8'((WIN_BASE << sel) - 8'h01);
    endfunction

    // register writes; read-only offsets ignore writes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_cfg0 <= RST_RX_CFG0;
            rx_cfg1 <= RST_RX_CFG1;
            rx_cfg2 <= RST_RX_CFG2;
            int_edge <= RST_INT_EDGE;
            term <= RST_TERM;
            gcfg1 <= RST_GLOBAL_CFG1;
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_RX_CFG0: rx_cfg0 <= reg_wdata;
                ADDR_RX_CFG1: rx_cfg1 <= reg_wdata;
                ADDR_RX_CFG2: rx_cfg2 <= reg_wdata;
                ADDR_INT_EDGE: int_edge <= reg_wdata;
                ADDR_TERM: term <= reg_wdata;
                ADDR_GLOBAL_CFG1: gcfg1 <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_RX_CFG0: reg_rdata <= rx_cfg0;
                ADDR_RX_CFG1: reg_rdata <= rx_cfg1;
                ADDR_RX_CFG2: reg_rdata <= rx_cfg2;
                ADDR_INT_EDGE: reg_rdata <= int_edge;
                ADDR_STATUS0: reg_rdata <= {7'h00, equalizer_out_of_range};
                ADDR_STATUS1: reg_rdata <= {3'h0, cable_atten_level};
                ADDR_INT_STATUS0: reg_rdata <= {7'h00, equalizer_irq_flag};
                ADDR_TERM: reg_rdata <= term;
                ADDR_GLOBAL_CFG1: reg_rdata <= gcfg1;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // analog controls follow their fields
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            term_enable <= 1'b0;
            term_sel <= 2'h0;
            monitor_gain_sel <= 2'h0;
            slicer_threshold_sel <= 2'h0;
            equalizer_enable <= 1'b0;
        end else begin
            term_enable <= !term[F_RTERM + 2];
            term_sel <= term[F_RTERM +: 2];
            monitor_gain_sel <= rx_cfg2[F_GAIN +: 2];
            slicer_threshold_sel <= rx_cfg2[F_SLICER_THRESHOLD_SEL +: 2];
            equalizer_enable <= rx_cfg1[F_EQ_EN];
        end
    end

    // source select: own slicer or another channel's line
    always_comb begin
        next_src = slicer_in;
        mon_on = 1'b0;
        if (mon_ch != 3'h0 && int'(mon_ch) < NCH) begin
            mon_on = 1'b1;
            next_src = monitor_channel_sel[3] ? mon_tx[mon_ch]
                                              : mon_rx[mon_ch];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            src_q <= '0;
            mon_q <= 1'b0;
            mark_d <= 1'b0;
        end else begin
            src_q <= next_src;
            mon_q <= mon_on;
            mark_d <= mark_q;
        end
    end

    assign mark_q = src_q.pos | src_q.neg;
    assign pulse_in = mark_q && !mark_d;
    assign nco_inc = e1_mode ? NCO_INC_E1 : NCO_INC_T1;

    // nco snaps to each pulse; with no pulses it free-runs at line rate
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase <= 16'h0000;
            ph_d <= 1'b0;
        end else begin
            phase <= pulse_in ? NCO_ALIGN : 16'(phase + nco_inc);
            ph_d <= phase[15];
        end
    end

    assign rise_ev = phase[15] && !ph_d;
    assign fall_ev = !phase[15] && ph_d;
    assign upd_ev = clk_edge_sel ? fall_ev : rise_ev;

    // marks are narrow, so hold them until the symbol strobe
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pos_seen <= 1'b0;
            neg_seen <= 1'b0;
        end else if (rise_ev) begin
            pos_seen <= 1'b0;
            neg_seen <= 1'b0;
        end else begin
            pos_seen <= pos_seen | src_q.pos;
            neg_seen <= neg_seen | src_q.neg;
        end
    end

    assign sym_pos = pos_seen | src_q.pos;
    assign sym_neg = (neg_seen | src_q.neg) & !sym_pos;
    assign new_m = sym_pos | sym_neg;
    assign viol = new_m && have_mark && (sym_pos == last_pol);

    // eight-symbol window: every mode except bypass sees the same latency
    always_comb begin
        next_p = {sh_p[6:0], sym_pos};
        next_n = {sh_n[6:0], sym_neg};
        w_m = next_p | next_n;
        hdb3 = e1_mode && viol && !w_m[1] && !w_m[2]
               && (!w_m[3] || next_p[3] == sym_pos);
        b8zs = !e1_mode && w_m[0] && w_m[1] && w_m[3] && w_m[4]
               && !w_m[2] && !w_m[5] && !w_m[6] && !w_m[7]
               && (next_p[4] != next_p[3]) && (next_p[1] == next_p[3])
               && (next_p[0] != next_p[1]);
        // outside AMI mode, violations that may open a substitution are not errors
        exempt = e1_mode ? hdb3
                 : ((!w_m[1] && !w_m[2] && !w_m[3])
                    || (!w_m[1] && w_m[2] && w_m[3]));
        subst = (rx_mode_sel == MODE_SUBST) && (hdb3 || b8zs);
        clr = 8'h00;
        if (subst) begin
            clr = b8zs ? 8'hff : 8'h0f;
        end
        next_cv = {sh_cv[6:0],
                   viol && ((rx_mode_sel == MODE_AMI) || !exempt)};
        next_p = next_p & ~clr;
        next_n = next_n & ~clr;
        next_cv = next_cv & ~clr;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sh_p <= 8'h00;
            sh_n <= 8'h00;
            sh_cv <= 8'h00;
            last_pol <= 1'b0;
            have_mark <= 1'b0;
        end else if (rise_ev) begin
            sh_p <= next_p;
            sh_n <= next_n;
            sh_cv <= next_cv;
            if (new_m) begin
                last_pol <= sym_pos;
                have_mark <= 1'b1;
            end
        end
    end

    // system side outputs
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_clock_out <= 1'b0;
            rx_data_pos <= 1'b0;
            rx_data_neg <= 1'b0;
            signal_loss_out <= 1'b0;
        end else if (power_down) begin
            rx_clock_out <= 1'b0;
            rx_data_pos <= 1'b0;
            rx_data_neg <= 1'b0;
            signal_loss_out <= 1'b0;
        end else begin
            signal_loss_out <= los_detect;
            if (rx_mode_sel == MODE_BYPASS) begin
                rx_clock_out <= src_q.pos ^ src_q.neg;
                rx_data_pos <= src_q.pos ^ rx_data_invert;
                rx_data_neg <= src_q.neg ^ rx_data_invert;
            end else begin
                rx_clock_out <= phase[15];
                if (upd_ev) begin
                    if (rx_mode_sel[1]) begin
                        rx_data_pos <= sh_p[7] ^ rx_data_invert;
                        rx_data_neg <= sh_n[7] ^ rx_data_invert;
                    end else begin
                        rx_data_pos <= (sh_p[7] | sh_n[7]) ^ rx_data_invert;
                        rx_data_neg <= sh_cv[7] ^ rx_data_invert;
                    end
                end
            end
        end
    end

    // monitored data onto the channel 1 transmit pair
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            line_tx_drive <= 1'b0;
            line_tx_pair_ch1 <= '0;
        end else begin
            line_tx_drive <= mon_q && remote_loopback;
            line_tx_pair_ch1 <= (mon_q && remote_loopback) ? src_q : '0;
        end
    end

    // observation window counted in recovered symbols
    assign win_end = rise_ev && (win_cnt >= win_limit(rx_cfg2[F_WIN +: 2]));
    assign pk = (amp_peak > peak) ? amp_peak : peak;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            win_cnt <= 8'h00;
            peak <= 8'h00;
            cable_atten_level <= 5'h00;
            equalizer_out_of_range <= 1'b0;
        end else if (win_end) begin
            win_cnt <= 8'h00;
            peak <= 8'h00;
            cable_atten_level <= ~pk[7:3];
            // a bypassed equalizer is never out of range
            equalizer_out_of_range <= rx_cfg1[F_EQ_EN]
                                      && (pk[7:3] == 5'h00);
        end else if (rise_ev) begin
            win_cnt <= 8'(win_cnt + 8'h01);
            peak <= pk;
        end
    end

    // status change event against last cycle's copy
    assign eq_event = equalizer_edge_sel
                      ? (equalizer_out_of_range != eqs_d)
                      : (equalizer_out_of_range && !eqs_d);
    assign clr_read = reg_read && (reg_addr == ADDR_INT_STATUS0);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            eqs_d <= 1'b0;
            equalizer_irq_flag <= 1'b0;
        end else begin
            eqs_d <= equalizer_out_of_range;
            // a new event beats the clearing read
            if (eq_event && !irq_mask) begin
                equalizer_irq_flag <= 1'b1;
            end else if (clr_read) begin
                equalizer_irq_flag <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_pd_outputs_low: assert property (
        power_down |=> !rx_clock_out && !rx_data_pos && !rx_data_neg
                       && !signal_loss_out)
        else $error("power down left an output high");
    a_term_write_map: assert property (
        reg_write && reg_addr == ADDR_TERM && !$past(reg_write)
        |=> ##1 term_enable == !$past(reg_wdata[F_RTERM + 2], 2))
        else $error("termination enable does not follow write");
    a_irq_any_edge: assert property (
        equalizer_edge_sel && !irq_mask
        && (equalizer_out_of_range != eqs_d) |=> equalizer_irq_flag)
        else $error("status change did not set flag");
    a_irq_fall_quiet: assert property (
        !equalizer_edge_sel && eqs_d && !equalizer_out_of_range
        && !equalizer_irq_flag |=> !equalizer_irq_flag)
        else $error("falling status set flag in rising mode");
    a_irq_read_clear: assert property (
        clr_read && !eq_event |=> !equalizer_irq_flag)
        else $error("read did not clear flag");
    a_irq_mask_hold: assert property (
        irq_mask && !equalizer_irq_flag |=> !equalizer_irq_flag)
        else $error("masked event set flag");
    a_atten_read: assert property (
        reg_read && reg_addr == ADDR_STATUS1
        |=> reg_rdata == {3'h0, $past(cable_atten_level)})
        else $error("attenuation readback wrong");
    a_eq_off_range: assert property (
        win_end && !rx_cfg1[F_EQ_EN] |=> !equalizer_out_of_range)
        else $error("bypassed equalizer reported out of range");
    a_bypass_xor_clk: assert property (
        rx_mode_sel == MODE_BYPASS && !power_down
        |=> rx_clock_out == $past(src_q.pos ^ src_q.neg))
        else $error("bypass clock is not rail xor");
    a_loop_tx_pair: assert property (
        mon_q && remote_loopback
        |=> line_tx_drive && line_tx_pair_ch1 == $past(src_q))
        else $error("monitored data missing on transmit pair");
endmodule
`default_nettype wire

// ===== bench/lrp_framer_model.sv
// Purpose: framer model that takes receive data off the recovered clock
// Assumes: fall_launch mirrors the clock edge bit the bench programs
// Notes: samples on the edge opposite the launch edge, as a framer would
`timescale 1ns/1ps
`default_nettype none
module lrp_framer_model (
    // recovered clock and data
    input wire logic rx_clock_out,
    input wire logic rx_data_pos,
    input wire logic rx_data_neg,
    // control
    input wire logic fall_launch,
    input wire logic clear,
    // tallies
    output int ones_seen,
    output int viol_seen
);
    logic smp_clk;
    // opposite edge keeps a half period of setup on either side
    assign smp_clk = rx_clock_out ^ ~fall_launch;
    always @(posedge smp_clk or posedge clear) begin
        if (clear) begin
            ones_seen <= 0;
            viol_seen <= 0;
        end else begin
            ones_seen <= ones_seen + int'(rx_data_pos);
            viol_seen <= viol_seen + int'(rx_data_neg);
        end
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for the receive path control block
// Assumes: 10 MHz ref_clk, register port with one-cycle strobes
// Notes: status polling is bounded, a stuck status shows as a mismatch
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lrp_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    lrp_rail_type slicer_in = 2'b00;
    logic [7:0] amp_peak = 8'hff;
    logic los_detect = 1'b0;
    lrp_rail_type [7:1] mon_rx = '0;
    lrp_rail_type [7:1] mon_tx = '0;
    logic remote_loopback = 1'b0;
    logic term_enable, equalizer_enable, line_tx_drive;
    logic [1:0] term_sel, monitor_gain_sel, slicer_threshold_sel;
    logic rx_clock_out, rx_data_pos, rx_data_neg;
    logic signal_loss_out, equalizer_irq_flag;
    lrp_rail_type line_tx_pair_ch1;
    logic fall_launch = 1'b0;
    logic clr = 1'b0;
    int ones_seen, viol_seen, failures = 0, samples_checked = 0;
    int cyc = 0, rises = 0;
    localparam logic [7:0] RA [7] = '{ADDR_RX_CFG0, ADDR_RX_CFG1,
        ADDR_RX_CFG2, ADDR_INT_EDGE, ADDR_TERM, ADDR_GLOBAL_CFG1, 8'h30};
    localparam logic [7:0] RV [7] = '{8'h00, 8'h01, 8'h08, 8'h00, 8'h00,
        8'h10, 8'h00};

    lrp_receive_path #(.NCH(8)) lrp_receive_path_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .slicer_in(slicer_in), .amp_peak(amp_peak),
        .los_detect(los_detect), .mon_rx(mon_rx), .mon_tx(mon_tx),
        .remote_loopback(remote_loopback), .term_enable(term_enable),
        .term_sel(term_sel), .monitor_gain_sel(monitor_gain_sel),
        .slicer_threshold_sel(slicer_threshold_sel),
        .equalizer_enable(equalizer_enable), .rx_clock_out(rx_clock_out),
        .rx_data_pos(rx_data_pos), .rx_data_neg(rx_data_neg),
        .signal_loss_out(signal_loss_out),
        .equalizer_irq_flag(equalizer_irq_flag),
        .line_tx_pair_ch1(line_tx_pair_ch1), .line_tx_drive(line_tx_drive));
    lrp_framer_model lrp_framer_model_i (.rx_clock_out(rx_clock_out),
        .rx_data_pos(rx_data_pos), .rx_data_neg(rx_data_neg),
        .fall_launch(fall_launch), .clear(clr), .ones_seen(ones_seen),
        .viol_seen(viol_seen));

    always #50 ref_clk = ~ref_clk;
    always @(posedge rx_clock_out) rises++;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, got,
                lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // status moves once per observation window, so wait on it boundedly
    task automatic poll(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        d = ~e;
        for (int i = 0; i < 600 && d !== e; i++)
            rd(a, d);
        chk(d, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_regs;
        logic [7:0] d;
        chk(term_enable, 1'b1);
        for (int i = 0; i < 7; i++) begin
            rd(RA[i], d);
            chk(d, RV[i]);
        end
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_TERM, 8'(k << 3));
            settle(2);
            chk({term_enable, term_sel}, {~k[2], k[1:0]});
        end
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_RX_CFG2, 8'(k * 17));
            settle(2);
            chk({monitor_gain_sel, slicer_threshold_sel}, 16'(k * 5));
        end
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_RX_CFG1, 8'(k));
            settle(2);
            chk(equalizer_enable, k[0]);
        end
        wr(ADDR_INT_STATUS0, 8'hff);
        rd(ADDR_INT_STATUS0, d);
        chk(d, 8'h00);
        $display("test regs done");
    endtask

    // m: 0 rising only, 1 both edges, 2 masked
    task automatic t_irq;
        logic [7:0] d;
        wr(ADDR_RX_CFG2, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_INT_EDGE, 8'(m));
            rd(ADDR_INT_STATUS0, d);
            @(posedge ref_clk) amp_peak <= 8'h04;
            poll(ADDR_STATUS0, 8'h01);
            settle(2);
            chk(equalizer_irq_flag, m != 2);
            rd(ADDR_INT_STATUS0, d);
            chk(d, 8'(m != 2));
            settle(1);
            chk(equalizer_irq_flag, 1'b0);
            @(posedge ref_clk) amp_peak <= 8'hff;
            poll(ADDR_STATUS0, 8'h00);
            settle(2);
            rd(ADDR_INT_STATUS0, d);
            chk(d, 8'(m == 1));
        end
        @(posedge ref_clk) amp_peak <= 8'h40;
        poll(ADDR_STATUS1, 8'h17);
        @(posedge ref_clk) amp_peak <= 8'hff;
        poll(ADDR_STATUS1, 8'h00);
        $display("test irq done");
    endtask

    task automatic t_rate;
        int n;
        wr(ADDR_RX_CFG0, 8'h10);
        for (int e = 1; e >= 0; e--) begin
            wr(ADDR_GLOBAL_CFG1, e ? 8'h10 : 8'h00);
            settle(20);
            n = rises;
            settle(10000);
            chk_in(rises - n, e ? 2046 : 1542, e ? 2050 : 1546);
        end
        $display("test rate done");
    endtask

    // alternating marks at about the E1 symbol rate, no violations
    task automatic t_data;
        wr(ADDR_GLOBAL_CFG1, 8'h10);
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_RX_CFG0, e ? 8'h14 : 8'h10);
            fall_launch <= e[0];
            settle(2);
            clr <= 1'b1;
            settle(1);
            clr <= 1'b0;
            for (int k = 0; k < 100; k++) begin
                @(posedge ref_clk);
                slicer_in <= k[0] ? 2'b01 : 2'b10;
                @(posedge ref_clk);
                slicer_in <= 2'b00;
                repeat (3) @(posedge ref_clk);
            end
            settle(60);
            chk_in(ones_seen, 50, 110);
            chk_in(viol_seen, 0, 0);
        end
        $display("test data done");
    endtask

    // groups + - (three zeros) - + -: the second minus is a 000V in E1
    // passes: single AMI, single with substitution, dual rail
    task automatic t_decode;
        int ones [3] = '{20, 16, 8};
        int cvs [3] = '{4, 0, 12};
        for (int e = 0; e < 3; e++) begin
            wr(ADDR_RX_CFG0, e == 0 ? 8'h14 : e == 1 ? 8'h04 : 8'h24);
            settle(2);
            clr <= 1'b1;
            settle(1);
            clr <= 1'b0;
            for (int k = 0; k < 20; k++) begin
                @(posedge ref_clk);
                slicer_in <= (k % 5 == 0 || k % 5 == 3) ? 2'b10 : 2'b01;
                @(posedge ref_clk);
                slicer_in <= 2'b00;
                repeat (k % 5 == 1 ? 18 : 3) @(posedge ref_clk);
            end
            settle(60);
            chk_in(ones_seen, ones[e], ones[e]);
            chk_in(viol_seen, cvs[e], cvs[e]);
        end
        $display("test decode done");
    endtask

    // v bit0 power down, bit1 invert, always in bypass
    task automatic t_bypass;
        @(posedge ref_clk) los_detect <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_RX_CFG0, 8'h30 | 8'(v));
            slicer_in <= 2'b10;
            settle(3);
            chk({rx_clock_out, rx_data_pos, rx_data_neg, signal_loss_out},
                v[0] ? 4'h0 : {2'b11 ^ {1'b0, v[1]}, v[1], 1'b1});
        end
        wr(ADDR_RX_CFG0, 8'h30);
        slicer_in <= 2'b11;
        los_detect <= 1'b0;
        settle(3);
        chk({rx_clock_out, signal_loss_out}, 2'b00);
        $display("test bypass done");
    endtask

    task automatic t_mon;
        @(posedge ref_clk);
        slicer_in <= 2'b00;
        remote_loopback <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            wr(ADDR_GLOBAL_CFG1, d ? 8'h1a : 8'h12);
            mon_rx[2] <= d ? 2'b00 : 2'b10;
            mon_tx[2] <= d ? 2'b01 : 2'b00;
            settle(4);
            chk({rx_data_pos, rx_data_neg, line_tx_drive, line_tx_pair_ch1},
                d ? 5'b01101 : 5'b10110);
        end
        @(posedge ref_clk) remote_loopback <= 1'b0;
        settle(4);
        chk(line_tx_drive, 1'b0);
        $display("test monitor done");
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle(2);
        t_regs();
        t_irq();
        t_rate();
        t_data();
        t_decode();
        t_bypass();
        t_mon();
        tally_and_finish();
    end
endmodule
`default_nettype wire
